// ---- src/ccc_axil_slave.sv ----
// axi4-lite slave front end: accepts one write and one read at a time
`timescale 1ns/10ps
module ccc_axil_slave (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic rvalid,
	input wire logic rready,
	output logic wr_go,
	output logic [11:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic rd_go,
	output logic [11:0] rd_addr
);
	logic aw_have_q;
	logic w_have_q;
	logic aw_have_d;
	logic w_have_d;
	logic bvalid_d;
	logic rvalid_d;

	// write address and data captured in either order
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
		end else if (clk_en) begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				wr_addr <= awaddr;
			end else if (wr_go) begin
				aw_have_q <= 1'b0;
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end else if (wr_go) begin
				w_have_q <= 1'b0;
			end
		end
	end

	assign wr_go = aw_have_q && w_have_q && !bvalid;

	// next values of the holding flags, so the ready outputs can come from flops
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		bvalid_d = bvalid;
		rvalid_d = rvalid;
		if (awvalid && awready) begin
			aw_have_d = 1'b1;
		end else if (wr_go) begin
			aw_have_d = 1'b0;
		end
		if (wvalid && wready) begin
			w_have_d = 1'b1;
		end else if (wr_go) begin
			w_have_d = 1'b0;
		end
		if (wr_go) begin
			bvalid_d = 1'b1;
		end else if (bready) begin
			bvalid_d = 1'b0;
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
		end else if (rready) begin
			rvalid_d = 1'b0;
		end
	end

	// ready outputs registered; high out of reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			awready <= 1'b1;
			wready <= 1'b1;
			arready <= 1'b1;
		end else if (clk_en) begin
			awready <= !aw_have_d && !bvalid_d;
			wready <= !w_have_d && !bvalid_d;
			arready <= !rvalid_d;
		end
	end

	// write response after both halves
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid <= 1'b0;
		end else if (clk_en) begin
			if (wr_go) begin
				bvalid <= 1'b1;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read accept; data follows next cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid <= 1'b0;
			rd_addr <= 12'h000;
		end else if (clk_en) begin
			if (rd_go) begin
				rvalid <= 1'b1;
				rd_addr <= araddr;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	assign rd_go = arvalid && !rvalid;
endmodule

// ---- src/ccc_line_walker.sv ----
// walks cache lines of a range or the whole cache, one line per cycle
`timescale 1ns/10ps
`include "ccc_params.svh"
module ccc_line_walker import ccc_pkg::*; #(
	parameter int ALL_LINES = `CCC_ALL_LINES
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	ccc_op_if.walk op
);
	logic [31:0] addr_q;
	logic [31:0] lines_q;
	logic [31:0] first_line;
	logic [31:0] last_line;
	logic [31:0] span_lines;

	// lines touched even partly count whole
	always_comb begin
		first_line = op.base >> `CCC_LINE_SHIFT;
		last_line = (op.base + op.bytes - 32'h1) >> `CCC_LINE_SHIFT;
		span_lines = (op.bytes == 32'h0) ? 32'h0 : (last_line - first_line + 32'h1);
	end

	// line counter and address
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= 32'h0;
			lines_q <= 32'h0;
		end else if (clk_en) begin
			if (op.start && lines_q == 32'h0) begin
				addr_q <= op.whole ? 32'h0 : {first_line[26:0], 5'h00};
				lines_q <= op.whole ? 32'(ALL_LINES) : span_lines;
			end else if (lines_q != 32'h0) begin
				addr_q <= addr_q + 32'(`CCC_LINE_BYTES);
				lines_q <= lines_q - 32'h1; // count down
			end
		end
	end

	assign op.busy = (lines_q != 32'h0);
	assign op.line_strobe = (lines_q != 32'h0);
	assign op.line_addr = addr_q;
	// remaining length in bytes, zero when done
	assign op.remain = {lines_q[26:0], 5'h00};
endmodule

// ---- src/ccc_op_if.sv ----
// start and progress signals between the register file and the line walker
`timescale 1ns/10ps
interface ccc_op_if;
	logic start;
	logic whole;
	logic [31:0] base;
	logic [31:0] bytes;
	logic busy;
	logic [31:0] remain;
	logic [31:0] line_addr;
	logic line_strobe;
	modport ctrl (output start, output whole, output base, output bytes,
		input busy, input remain, input line_addr, input line_strobe);
	modport walk (input start, input whole, input base, input bytes,
		output busy, output remain, output line_addr, output line_strobe);
endinterface

// ---- src/ccc_params.svh ----
// register offsets, field layout, reset values and line geometry for the cache control block
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

`define CCC_OFS_SIZE_CFG 12'h000
`define CCC_OFS_PROG_CC 12'h004
`define CCC_OFS_DATA_CC 12'h008
`define CCC_OFS_L2_CFG 12'h00c
`define CCC_OFS_INV_BASE 12'h010
`define CCC_OFS_INV_COUNT 12'h014
`define CCC_OFS_INV_ALL 12'h018
`define CCC_OFS_STATUS 12'h01c
`define CCC_OFS_MAR0 12'h100
`define CCC_MAR_WORDS 16
`define CCC_MAR_TOP 12'h13c

`define CCC_POS_PSIZE 0
`define CCC_POS_DSIZE 4
`define CCC_POS_MODE 0
`define CCC_POS_PRIOR 16
`define CCC_POS_CACHEABLE 0

`define CCC_RST_L1_SIZE 3'h0
`define CCC_RST_L2_SIZE 2'h0
`define CCC_LINE_BYTES 32
`define CCC_LINE_SHIFT 5
`define CCC_ALL_LINES 1024

`endif

// ---- src/ccc_pkg.sv ----
// types shared by the cache control block
package ccc_pkg;
	typedef enum logic [2:0] {
		CCC_L1_0K,
		CCC_L1_4K,
		CCC_L1_8K,
		CCC_L1_16K,
		CCC_L1_32K
	} ccc_l1_size_e;
	typedef enum logic [1:0] {
		CCC_L2_32K,
		CCC_L2_64K,
		CCC_L2_128K,
		CCC_L2_256K
	} ccc_l2_size_e;
	typedef enum logic {
		CCC_MODE_NORMAL,
		CCC_MODE_FREEZE
	} ccc_mode_e;
endpackage

// ---- src/ccc_top.sv ----
// cache size, cacheability, freeze and invalidate control with an axi4-lite register file
`timescale 1ns/10ps
`include "ccc_params.svh"
module ccc_top import ccc_pkg::*; #(
	parameter int MAR_WORDS = `CCC_MAR_WORDS,
	parameter int ALL_LINES = `CCC_ALL_LINES
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [2:0] prog_size,
	output logic [2:0] data_size,
	output logic [1:0] l2_size,
	output logic prog_frozen,
	output logic data_frozen,
	output logic [32*`CCC_MAR_WORDS-1:0] cacheable,
	output logic inval_strobe,
	output logic [31:0] inval_addr,
	output logic op_busy
);
	logic wr_go;
	logic rd_go;
	logic [11:0] wr_addr;
	logic [11:0] rd_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [2:0] psize_q;
	logic [2:0] dsize_q;
	logic [1:0] l2size_q;
	ccc_mode_e pmode_q;
	ccc_mode_e dmode_q;
	ccc_mode_e pprior_q;
	ccc_mode_e dprior_q;
	logic [31:0] mar_q [MAR_WORDS];
	logic [31:0] base_q;
	logic [31:0] bytes_q;
	logic start_q;
	logic whole_q;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] rd_word;
	logic [11:0] mar_idx_w;
	logic [11:0] mar_idx_r;
	logic awbusy_unused;
	logic awready_i;
	logic wready_i;
	logic bvalid_i;
	logic arready_i;
	logic rvalid_i;

	ccc_op_if op ();

	ccc_axil_slave u_bus (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(awready_i),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(wready_i),
		.bvalid(bvalid_i),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(arready_i),
		.rvalid(rvalid_i),
		.rready(s_axi_rready),
		.wr_go(wr_go),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_go(rd_go),
		.rd_addr()
	);

	ccc_line_walker #(.ALL_LINES(ALL_LINES)) u_walk (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.op(op)
	);

	assign s_axi_awready = awready_i;
	assign s_axi_wready = wready_i;
	assign s_axi_bvalid = bvalid_i;
	assign s_axi_arready = arready_i;
	assign s_axi_rvalid = rvalid_i;
	assign rd_addr = s_axi_araddr;
	assign awbusy_unused = ^{s_axi_awprot, s_axi_arprot, wr_strb};

	// start of the walker
	assign op.start = start_q;
	assign op.whole = whole_q;
	assign op.base = base_q;
	assign op.bytes = bytes_q;

	// address decode for writes and reads
	assign mar_idx_w = (wr_addr - `CCC_OFS_MAR0) >> 2;
	assign mar_idx_r = (rd_addr - `CCC_OFS_MAR0) >> 2;

	always_comb begin
		wr_ok = 1'b0;
		case (wr_addr)
			`CCC_OFS_SIZE_CFG, `CCC_OFS_PROG_CC, `CCC_OFS_DATA_CC, `CCC_OFS_L2_CFG,
			`CCC_OFS_INV_BASE, `CCC_OFS_INV_COUNT, `CCC_OFS_INV_ALL: wr_ok = 1'b1;
			default: wr_ok = (wr_addr >= `CCC_OFS_MAR0) && (wr_addr <= `CCC_MAR_TOP)
				&& (wr_addr[1:0] == 2'b00);
		endcase
	end

	// size registers; only legal codes are taken
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			psize_q <= `CCC_RST_L1_SIZE;
			dsize_q <= `CCC_RST_L1_SIZE;
			l2size_q <= `CCC_RST_L2_SIZE;
		end else if (clk_en && wr_go) begin
			if (wr_addr == `CCC_OFS_SIZE_CFG) begin
				if (wr_data[`CCC_POS_PSIZE +: 3] <= 3'(CCC_L1_32K)) begin
					psize_q <= wr_data[`CCC_POS_PSIZE +: 3];
				end
				if (wr_data[`CCC_POS_DSIZE +: 3] <= 3'(CCC_L1_32K)) begin
					dsize_q <= wr_data[`CCC_POS_DSIZE +: 3];
				end
			end
			if (wr_addr == `CCC_OFS_L2_CFG) begin
				l2size_q <= wr_data[1:0];
			end
		end
	end

	// freeze control; old mode kept for the prior field
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pmode_q <= CCC_MODE_NORMAL;
			dmode_q <= CCC_MODE_NORMAL;
			pprior_q <= CCC_MODE_NORMAL;
			dprior_q <= CCC_MODE_NORMAL;
		end else if (clk_en && wr_go) begin
			if (wr_addr == `CCC_OFS_PROG_CC) begin
				pprior_q <= pmode_q;
				pmode_q <= ccc_mode_e'(wr_data[`CCC_POS_MODE]);
			end
			if (wr_addr == `CCC_OFS_DATA_CC) begin
				dprior_q <= dmode_q;
				dmode_q <= ccc_mode_e'(wr_data[`CCC_POS_MODE]);
			end
		end
	end

	// cacheable bits, cleared at reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < MAR_WORDS; i++) begin
				mar_q[i] <= 32'h0;
			end
		end else if (clk_en && wr_go && wr_ok && wr_addr >= `CCC_OFS_MAR0) begin
			mar_q[mar_idx_w[3:0]] <= {31'h0, wr_data[`CCC_POS_CACHEABLE]};
		end
	end

	// invalidate base, count and launch; count and launch writes while busy are dropped
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			base_q <= 32'h0;
			bytes_q <= 32'h0;
			start_q <= 1'b0;
			whole_q <= 1'b0;
		end else if (clk_en) begin
			start_q <= 1'b0;
			if (wr_go && wr_addr == `CCC_OFS_INV_BASE) begin
				base_q <= wr_data;
			end
			if (wr_go && !op.busy && !start_q) begin
				if (wr_addr == `CCC_OFS_INV_COUNT && wr_data != 32'h0) begin
					bytes_q <= wr_data;
					whole_q <= 1'b0;
					start_q <= 1'b1;
				end
				if (wr_addr == `CCC_OFS_INV_ALL && wr_data[0]) begin
					whole_q <= 1'b1;
					start_q <= 1'b1;
				end
			end
		end
	end

	// read mux
	always_comb begin
		rd_ok = 1'b1;
		rd_word = 32'h0;
		case (rd_addr)
			`CCC_OFS_SIZE_CFG: rd_word = {25'h0, dsize_q, 1'b0, psize_q};
			`CCC_OFS_PROG_CC: rd_word = {15'h0, pprior_q, 15'h0, pmode_q};
			`CCC_OFS_DATA_CC: rd_word = {15'h0, dprior_q, 15'h0, dmode_q};
			`CCC_OFS_L2_CFG: rd_word = {30'h0, l2size_q};
			`CCC_OFS_INV_BASE: rd_word = base_q;
			`CCC_OFS_INV_COUNT: rd_word = op.remain;
			`CCC_OFS_INV_ALL: rd_word = {31'h0, op.busy & whole_q};
			`CCC_OFS_STATUS: rd_word = {31'h0, !(op.busy || start_q)}; // done
			default: begin
				rd_ok = (rd_addr >= `CCC_OFS_MAR0) && (rd_addr <= `CCC_MAR_TOP)
					&& (rd_addr[1:0] == 2'b00);
				rd_word = rd_ok ? mar_q[mar_idx_r[3:0]] : 32'h0;
			end
		endcase
	end

	// registered bus answers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
			s_axi_bresp <= 2'b00;
		end else if (clk_en) begin
			if (rd_go) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
			end
			if (wr_go) begin
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
		end
	end

	// registered cache-facing outputs
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prog_size <= `CCC_RST_L1_SIZE;
			data_size <= `CCC_RST_L1_SIZE;
			l2_size <= `CCC_RST_L2_SIZE;
			prog_frozen <= 1'b0;
			data_frozen <= 1'b0;
			cacheable <= '0;
			inval_strobe <= 1'b0;
			inval_addr <= 32'h0;
			op_busy <= 1'b0;
		end else if (clk_en) begin
			prog_size <= psize_q;
			data_size <= dsize_q;
			l2_size <= l2size_q;
			prog_frozen <= (pmode_q == CCC_MODE_FREEZE);
			data_frozen <= (dmode_q == CCC_MODE_FREEZE);
			for (int i = 0; i < MAR_WORDS; i++) begin
				cacheable[i*32 +: 32] <= {31'h0, mar_q[i][0]};
			end
			inval_strobe <= op.line_strobe;
			inval_addr <= op.line_addr;
			op_busy <= op.busy || start_q;
		end
	end
endmodule

// ---- test/ccc_monitor.sv ----
// concurrent checks on the cache control block ports
`timescale 1ns/10ps
`include "ccc_params.svh"
module ccc_monitor import ccc_pkg::*; #(
	parameter int MAR_WORDS = `CCC_MAR_WORDS,
	parameter int ALL_LINES = `CCC_ALL_LINES
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [2:0] prog_size,
	input wire logic [2:0] data_size,
	input wire logic [1:0] l2_size,
	input wire logic prog_frozen,
	input wire logic data_frozen,
	input wire logic [32*`CCC_MAR_WORDS-1:0] cacheable,
	input wire logic inval_strobe,
	input wire logic [31:0] inval_addr,
	input wire logic op_busy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// a started operation walks lines soon
	property p_busy_walks; $rose(op_busy) |-> ##[0:4] inval_strobe; endproperty
	a_busy_walks: assert property (p_busy_walks) else $error("busy without walk");
	// consecutive lines step by one line while enabled
	property p_line_step; inval_strobe && $past(inval_strobe) && $past(clk_en) |->
		inval_addr == $past(inval_addr) + 32'h20; endproperty
	a_line_step: assert property (p_line_step) else $error("line step wrong");
	// whole lines only
	property p_line_whole; inval_strobe |-> inval_addr[4:0] == 5'h0; endproperty
	a_line_whole: assert property (p_line_whole) else $error("line unaligned");
	// first-level sizes stay among the five settings
	property p_size_legal; prog_size <= 3'h4 && data_size <= 3'h4; endproperty
	a_size_legal: assert property (p_size_legal) else $error("size code bad");
	// settings move only after a write
	property p_cfg_quiet; !s_axi_wvalid [*4] |=>
		$stable({prog_size, data_size, l2_size, prog_frozen, data_frozen, cacheable}); endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("setting moved alone");
	// no operation starts without a write
	property p_op_quiet; !s_axi_wvalid [*6] ##1 !op_busy |=> !op_busy; endproperty
	a_op_quiet: assert property (p_op_quiet) else $error("op started alone");
	// read answer stands until taken
	property p_read_holds; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_read_holds: assert property (p_read_holds) else $error("read answer dropped");
	// done comes only after the last line
	property p_done_after_lines; $fell(op_busy) |->
		$past(inval_strobe, 1) || $past(inval_strobe, 2) || $past(inval_strobe, 3); endproperty
	a_done_after_lines: assert property (p_done_after_lines) else $error("done early");
endmodule

// ---- test/ccc_top_tb.sv ----
// register-level bench for the cache control block
`timescale 1ns/10ps
`include "ccc_params.svh"
module ccc_top_tb;
	localparam int ALL = 16;
	logic core_clk = 0, arst_n = 0, clk_en = 1;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, prog_size, data_size;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, prog_frozen, data_frozen, inval_strobe, op_busy;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, inval_addr, first_addr, last_addr;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, l2_size;
	logic [32*`CCC_MAR_WORDS-1:0] cacheable;
	int checks = 0, miscompares = 0, n_lines = 0;
	ccc_top #(.ALL_LINES(ALL)) i_ccc_top (.*);
	// clock at 25 MHz
	always #20 core_clk = ~core_clk;
	// record invalidated lines; a line held while disabled counts once
	always @(negedge core_clk) if (inval_strobe === 1'b1 && clk_en) begin
		if (n_lines == 0) first_addr = inval_addr;
		last_addr = inval_addr;
		n_lines++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one write; answer awaited under a bound
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		logic ta, tw, tb;
		logic [1:0] rs;
		n = 0;
		tb = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb && n < 100) begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		chk({29'h0, tb, rs}, {29'h0, 1'b1, er}, "write response");
		@(posedge core_clk);
	endtask
	// one read; data and response compared
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0,
		input int late = 0);
		int n;
		logic ta, tr;
		logic [1:0] rs;
		logic [31:0] v;
		n = 0;
		tr = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (late == 0);
		while (!tr && n < 100) begin
			@(negedge core_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid && s_axi_rready;
			rs = s_axi_rresp;
			v = s_axi_rdata;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
			if (late > 0 && n == late) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		chk({29'h0, tr, rs}, {29'h0, 1'b1, er}, "read response");
		chk(v, exp, "read data");
		@(posedge core_clk);
	endtask
	// wait for the operation to start and finish
	task automatic wait_idle;
		int n;
		n = 0;
		while (op_busy !== 1'b1 && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		while (op_busy !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chk({31'h0, op_busy}, 32'h0, "operation end");
		@(posedge core_clk);
	endtask
	// block invalidate of a range, then expected line count and ends
	task automatic blk(input logic [31:0] b, input logic [31:0] c, input int ln,
		input logic [31:0] la);
		n_lines = 0;
		wr(`CCC_OFS_INV_BASE, b);
		wr(`CCC_OFS_INV_COUNT, c);
		wait_idle;
		chk(n_lines, ln, "lines walked");
		chk(first_addr, b & 32'hffffffe0, "first line");
		chk(last_addr, la, "last line");
		rd(`CCC_OFS_INV_COUNT, 32'h0);
		rd(`CCC_OFS_STATUS, 32'h1);
	endtask
	// watchdog
	initial begin
		#400000;
		miscompares++;
		report_and_stop;
	end
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chk({31'h0, |cacheable}, 32'h0, "cacheable after reset");
		rd(`CCC_OFS_MAR0, 32'h0);
		rd(`CCC_MAR_TOP, 32'h0);
		wr(`CCC_OFS_MAR0 + 12'h00c, 32'h1);
		rd(`CCC_OFS_MAR0 + 12'h00c, 32'h1);
		chk(cacheable[127:96], 32'h1, "region enabled");
		chk({31'h0, |cacheable[95:0]}, 32'h0, "other regions");
		for (int i = 0; i < 5; i++) begin
			wr(`CCC_OFS_SIZE_CFG, (i << 4) | (4 - i));
			rd(`CCC_OFS_SIZE_CFG, (i << 4) | (4 - i));
			chk({26'h0, data_size, prog_size}, (i << 3) | (4 - i), "first sizes");
		end
		wr(`CCC_OFS_SIZE_CFG, 32'h45);
		rd(`CCC_OFS_SIZE_CFG, 32'h40);
		for (int i = 0; i < 4; i++) begin
			wr(`CCC_OFS_L2_CFG, i);
			rd(`CCC_OFS_L2_CFG, i);
			chk({30'h0, l2_size}, i, "second-level size");
		end
		rd(`CCC_OFS_L2_CFG, 32'h3, 2'h0, 3);
		wr(`CCC_OFS_PROG_CC, 32'h1);
		rd(`CCC_OFS_PROG_CC, 32'h1);
		wr(`CCC_OFS_DATA_CC, 32'h1);
		rd(`CCC_OFS_DATA_CC, 32'h1);
		chk({30'h0, prog_frozen, data_frozen}, 32'h3, "frozen");
		wr(`CCC_OFS_DATA_CC, 32'h1);
		rd(`CCC_OFS_DATA_CC, 32'h10001);
		wr(`CCC_OFS_PROG_CC, 32'h0);
		rd(`CCC_OFS_PROG_CC, 32'h10000);
		chk({31'h0, prog_frozen}, 32'h0, "unfrozen");
		rd(12'h200, 32'h0, 2'h2);
		wr(12'h204, 32'h5, 2'h2);
		blk(32'hc0000000, 32'hc8, 7, 32'hc00000c0);
		blk(32'hc0000010, 32'h28, 2, 32'hc0000020);
		n_lines = 0;
		wr(`CCC_OFS_INV_ALL, 32'h1);
		wr(`CCC_OFS_INV_COUNT, 32'h40);
		rd(`CCC_OFS_STATUS, 32'h0);
		clk_en <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk({31'h0, op_busy}, 32'h1, "operation held while disabled");
		clk_en <= 1'b1;
		wait_idle;
		chk(n_lines, ALL, "whole cache lines");
		rd(`CCC_OFS_STATUS, 32'h1);
		report_and_stop;
	end
endmodule
bind ccc_top ccc_monitor #(.MAR_WORDS(MAR_WORDS), .ALL_LINES(ALL_LINES)) i_ccc_monitor (.*);
